//--- design/tag_core.sv
// command interpreter and memory of a vicinity tag
// assumes RST_N follows field power-up and the link delivers decoded frames
`timescale 1ns/100ps
`default_nettype none
`include "tag_core_params.svh"

module tag_core #(
    // factory identifier, arbitrary value
    parameter logic [63:0] UNIQUE_IDENTIFIER = 64'h0123456789abcdef
)(
    // core clock and field reset
    input wire logic MCLK,
    input wire logic RST_N,
    // link clock
    input wire logic LCLK,
    // request from the link
    input wire logic REQ_VALID,
    input wire tag_core_pkg::req_t REQ,
    output logic REQ_READY,
    // answer to the link
    output logic RSP_VALID,
    output tag_core_pkg::rsp_t RSP
);

    tag_core_pkg::core_t q, d;
    tag_core_pkg::req_t c;
    logic go;

    tag_link_xfer u_xfer (
        .mclk(MCLK),
        .rst_n(RST_N),
        .go(go),
        .cmd(c),
        .rsp_go(q.rsp_go),
        .rsp_in(q.rsp),
        .lclk(LCLK),
        .req_valid(REQ_VALID),
        .req_in(REQ),
        .req_ready(REQ_READY),
        .rsp_valid(RSP_VALID),
        .rsp_out(RSP)
    );

    // access right of a block: {read, write}
    function automatic logic [1:0] access(input logic [4:0] p, input logic [1:0] pw);
        logic pres;
        pres = (p[`PROT_PW_HI:`PROT_PW_LO] != 2'h0) && (p[`PROT_PW_HI:`PROT_PW_LO] == pw);
        access = 2'b11;
        if (p[`PROT_LOCK]) begin
            case (p[`PROT_RW_HI:`PROT_RW_LO])
                2'b00: access = {1'b1, pres};
                2'b01: access = 2'b11;
                2'b10: access = {pres, pres};
                default: access = {pres, 1'b0};
            endcase
        end
    endfunction : access

    always_comb begin
        logic [1:0] rw;
        logic [5:0] bi;
        logic [1:0] pi;
        logic in_rng;
        logic adr_ok;
        logic sel_ok;
        logic [7:0] b;
        logic [4:0] tp;
        rw = 2'b00;
        bi = c.blk[5:0];
        pi = c.param[1:0];
        in_rng = c.blk < 8'(`NBLK);
        adr_ok = !c.flags[`FLG_ADDRESS] || (c.unique_identifier == UNIQUE_IDENTIFIER);
        sel_ok = !c.flags[`FLG_SELECT] || (q.mode == tag_core_pkg::MODE_SELECTED);
        b = 8'h00;
        tp = 5'h00;
        d = q;
        d.rsp_go = 1'b0;
        if (go) begin
            // every answer is caused by one taken request
            d.rsp_go = 1'b1;
            d.rsp = '0;
            if (q.mode == tag_core_pkg::MODE_DEAD) begin
                d.rsp.silent = 1'b1;
            end else if (c.cmd == `CMD_INVENTORY || c.cmd == `CMD_INV_INIT
                         || c.cmd == `CMD_FAST_INV_INIT) begin
                // anticollision answer: storage id and identifier
                d.rsp.b0 = q.storage_format_id;
                d.rsp.data = UNIQUE_IDENTIFIER;
                if (q.mode == tag_core_pkg::MODE_QUIET) begin
                    d.rsp.silent = 1'b1;
                end
                if (c.cmd != `CMD_INVENTORY && !q.initiated) begin
                    d.rsp.silent = 1'b1;
                end
                if (c.flags[`FLG_AFI] && c.param != 8'h00 && c.param != q.application_family_id) begin
                    d.rsp.silent = 1'b1;
                end
            end else if (!adr_ok || !sel_ok) begin
                d.rsp.silent = 1'b1;
            end else if (q.mode == tag_core_pkg::MODE_QUIET && !c.flags[`FLG_ADDRESS]) begin
                d.rsp.silent = 1'b1;
            end else begin
                case (c.cmd)
                    `CMD_STAY_QUIET: begin
                        d.rsp.silent = 1'b1;
                        if (c.flags[`FLG_ADDRESS]) begin
                            d.mode = tag_core_pkg::MODE_QUIET;
                        end
                    end
                    `CMD_SELECT: begin
                        if (c.flags[`FLG_ADDRESS]) begin
                            d.mode = tag_core_pkg::MODE_SELECTED;
                        end else begin
                            d.rsp.silent = 1'b1;
                        end
                    end
                    `CMD_RESET_RDY: begin
                        d.mode = tag_core_pkg::MODE_READY;
                    end
                    `CMD_INIT, `CMD_FAST_INIT: begin
                        d.initiated = 1'b1;
                        d.rsp.b0 = q.storage_format_id;
                        d.rsp.data = UNIQUE_IDENTIFIER;
                    end
                    `CMD_READ_BLK, `CMD_FAST_READ: begin
                        rw = access(q.prot[bi], q.pw_sel);
                        if (!in_rng) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_RANGE;
                        end else if (!rw[1]) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_DENIED;
                        end else begin
                            d.rsp.stat = {3'h0, q.prot[bi]};
                            d.rsp.data = {32'h0, q.mem[bi]};
                        end
                    end
                    `CMD_WRITE_BLK: begin
                        rw = access(q.prot[bi], q.pw_sel);
                        if (!in_rng) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_RANGE;
                        end else if (!rw[0]) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else begin
                            d.mem[bi] = c.data;
                        end
                    end
                    `CMD_LOCK_BLK: begin
                        if (!in_rng) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_RANGE;
                        end else if (q.prot[bi][`PROT_LOCK]) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else begin
                            // no password link, no write until RST_N clears it
                            d.prot[bi] = `PROT_HARDLOCK;
                        end
                    end
                    `CMD_WRITE_AFI: begin
                        if (q.afi_lock) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else begin
                            d.application_family_id = c.data[7:0];
                        end
                    end
                    `CMD_LOCK_AFI: begin
                        if (q.afi_lock) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else begin
                            d.afi_lock = 1'b1;
                        end
                    end
                    `CMD_WRITE_DSF: begin
                        if (q.storage_format_id_lock) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else begin
                            d.storage_format_id = c.data[7:0];
                        end
                    end
                    `CMD_LOCK_DSF: begin
                        if (q.storage_format_id_lock) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else begin
                            d.storage_format_id_lock = 1'b1;
                        end
                    end
                    `CMD_SYS_INFO: begin
                        d.rsp.b0 = q.storage_format_id;
                        d.rsp.b1 = q.application_family_id;
                        d.rsp.data = UNIQUE_IDENTIFIER;
                    end
                    `CMD_MULTI_SEC: begin
                        if (!in_rng) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_RANGE;
                        end else begin
                            // four consecutive statuses, past the end reads zero
                            for (int i = 0; i < 4; i++) begin
                                b = c.blk + 8'(i);
                                if (b < 8'(`NBLK)) begin
                                    d.rsp.data[i*8 +: 8] = {3'h0, q.prot[b[5:0]]};
                                end
                            end
                        end
                    end
                    `CMD_KILL: begin
                        if (q.pprot[0][`PROT_LOCK] && c.data == q.pwd[0]) begin
                            d.mode = tag_core_pkg::MODE_DEAD;
                        end else begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_PWD;
                        end
                    end
                    `CMD_WRITE_PWD: begin
                        rw = access(q.pprot[pi], q.pw_sel);
                        if (!rw[0]) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_DENIED;
                        end else begin
                            d.pwd[pi] = c.data;
                        end
                    end
                    `CMD_LOCK_PWD: begin
                        tp = c.flags[`FLG_PWAREA] ? q.pprot[pi] : q.prot[bi];
                        if (!c.flags[`FLG_PWAREA] && !in_rng) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_RANGE;
                        end else if (tp[`PROT_LOCK]) begin
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_LOCKED;
                        end else if (c.flags[`FLG_PWAREA]) begin
                            d.pprot[pi] = {c.data[4:1], 1'b1};
                        end else begin
                            d.prot[bi] = {c.data[4:1], 1'b1};
                        end
                    end
                    `CMD_PRESENT_PWD: begin
                        if (pi != 2'h0 && q.pprot[pi][`PROT_LOCK] && c.data == q.pwd[pi]) begin
                            d.pw_sel = pi;
                        end else begin
                            d.pw_sel = 2'h0;
                            d.rsp.err = 1'b1;
                            d.rsp.code = `ERR_PWD;
                        end
                    end
                    default: begin
                        d.rsp.err = 1'b1;
                        d.rsp.code = `ERR_UNSUP;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : tag_core

`default_nettype wire

//--- design/tag_core_params.svh
// constants for the vicinity tag command core: codes, flags, field positions
// assumes a link front end that delivers whole decoded request frames
//
// Contract
// - user memory is 64 blocks of 32 bits, numbered 0 to 63
// - every user block has its own protection setting
// - block read or write happens only when protection permits it
// - a permitted write replaces all 32 bits of the block
// - 64-bit factory identifier, not a user block, used by inventory
// - kill code and three passwords held in four 32-bit blocks
// - after stay quiet, no answer to any inventory command
// - when selected, commands with the select flag are processed
// - reset to ready puts the tag in the ready state
// - block read returns 32 data bits plus the block lock status
// - write block only on an unlocked block, else contents unchanged; the code also writes a locked block when its access bits and password permit
// - a block locked by lock block refuses any later change; the code clears the lock and the block contents at RST_N
// - application family id written, then frozen by its lock command
// - storage format id written, then frozen by its lock command
// - multiple block security status returns the blocks' protection
// - initiated inventories answered only after an initiate command
// - a valid kill silences the tag for good; the code clears the kill at RST_N and the tag answers again
// - write password stores 32 bits into the chosen password block
// - lock password sets the protection bits of the chosen block
// - a correct password relaxes access of all blocks linked to it
// - the tag answers received commands only, never unsolicited
// - protection: lock bit 0, access bits 1-2, link bits 3-4
// - link code 00 none, 01/10/11 passwords 1/2/3
// - lock password on a locked block errors and changes nothing
`ifndef TAG_CORE_PARAMS_SVH
`define TAG_CORE_PARAMS_SVH

`define NBLK 64
`define NPWD 4

// command codes
`define CMD_INVENTORY 8'h01
`define CMD_STAY_QUIET 8'h02
`define CMD_READ_BLK 8'h20
`define CMD_WRITE_BLK 8'h21
`define CMD_LOCK_BLK 8'h22
`define CMD_SELECT 8'h25
`define CMD_RESET_RDY 8'h26
`define CMD_WRITE_AFI 8'h27
`define CMD_LOCK_AFI 8'h28
`define CMD_WRITE_DSF 8'h29
`define CMD_LOCK_DSF 8'h2a
`define CMD_SYS_INFO 8'h2b
`define CMD_MULTI_SEC 8'h2c
`define CMD_KILL 8'ha6
`define CMD_WRITE_PWD 8'ha7
`define CMD_LOCK_PWD 8'ha8
`define CMD_PRESENT_PWD 8'ha9
`define CMD_FAST_READ 8'hc0
`define CMD_FAST_INIT 8'hc1
`define CMD_FAST_INV_INIT 8'hc2
`define CMD_INIT 8'hd2
`define CMD_INV_INIT 8'hd1

// request flag bit positions
`define FLG_AFI 4
`define FLG_SELECT 4
`define FLG_ADDRESS 5
`define FLG_PWAREA 7

// protection field positions
`define PROT_LOCK 0
`define PROT_RW_LO 1
`define PROT_RW_HI 2
`define PROT_PW_LO 3
`define PROT_PW_HI 4
`define PROT_HARDLOCK 5'h01
`define PROT_RESET 5'h00

// error codes
`define ERR_UNSUP 8'h01
`define ERR_RANGE 8'h10
`define ERR_LOCKED 8'h11
`define ERR_DENIED 8'h12
`define ERR_PWD 8'h13

`endif

//--- design/tag_core_pkg.sv
// types shared by the tag command core and its link crossing
// assumes tag_core_params.svh is on the include path
`include "tag_core_params.svh"

package tag_core_pkg;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] cmd;
        logic [7:0] blk;
        logic [7:0] param;
        logic [63:0] unique_identifier;
        logic [31:0] data;
    } req_t;

    typedef struct packed {
        logic silent;
        logic err;
        logic [7:0] code;
        logic [7:0] stat;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [63:0] data;
    } rsp_t;

    typedef enum logic [1:0] {
        MODE_READY,
        MODE_SELECTED,
        MODE_QUIET,
        MODE_DEAD
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic initiated;
        logic [1:0] pw_sel;
        logic [7:0] application_family_id;
        logic afi_lock;
        logic [7:0] storage_format_id;
        logic storage_format_id_lock;
        logic [`NBLK-1:0][31:0] mem;
        logic [`NBLK-1:0][4:0] prot;
        logic [`NPWD-1:0][31:0] pwd;
        logic [`NPWD-1:0][4:0] pprot;
        rsp_t rsp;
        logic rsp_go;
    } core_t;

    typedef struct packed {
        req_t req;
        logic busy;
        logic req_tog;
        logic r1;
        logic r2;
        logic rprev;
        logic rsp_vld;
        rsp_t rsp;
    } lnk_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic rsp_tog;
        rsp_t rsp;
    } mside_t;

endpackage : tag_core_pkg

//--- design/tag_link_xfer.sv
// request/answer crossing between the link clock and the core clock
// assumes requests come from logic on lclk and stay one per answer
`timescale 1ns/100ps
`default_nettype none

module tag_link_xfer (
    // core clock side
    input wire logic mclk,
    input wire logic rst_n,
    output logic go,
    output tag_core_pkg::req_t cmd,
    input wire logic rsp_go,
    input wire tag_core_pkg::rsp_t rsp_in,
    // link side
    input wire logic lclk,
    input wire logic req_valid,
    input wire tag_core_pkg::req_t req_in,
    output logic req_ready,
    output logic rsp_valid,
    output tag_core_pkg::rsp_t rsp_out
);

    tag_core_pkg::lnk_t l_q, l_d;
    tag_core_pkg::mside_t m_q, m_d;
    logic rs1, rs2;

    // reset brought into the link domain
    always_ff @(posedge lclk) begin
        rs1 <= rst_n;
        rs2 <= rs1;
    end

    assign req_ready = !l_q.busy;
    assign rsp_valid = l_q.rsp_vld;
    assign rsp_out = l_q.rsp;
    assign cmd = l_q.req;
    assign go = m_q.s2 ^ m_q.prev;

    // link side: hold request, toggle, wait for answer toggle
    always_comb begin
        l_d = l_q;
        l_d.rsp_vld = 1'b0;
        l_d.r1 = m_q.rsp_tog;
        l_d.r2 = l_q.r1;
        l_d.rprev = l_q.r2;
        if (req_valid && !l_q.busy) begin
            l_d.req = req_in;
            l_d.busy = 1'b1;
            l_d.req_tog = !l_q.req_tog;
        end
        if (l_q.r2 ^ l_q.rprev) begin
            l_d.busy = 1'b0;
            l_d.rsp = m_q.rsp;
            l_d.rsp_vld = !m_q.rsp.silent;
        end
    end

    always_ff @(posedge lclk) begin
        if (!rs2) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // core side: detect request toggle, post answer
    always_comb begin
        m_d = m_q;
        m_d.s1 = l_q.req_tog;
        m_d.s2 = m_q.s1;
        m_d.prev = m_q.s2;
        if (rsp_go) begin
            m_d.rsp = rsp_in;
            m_d.rsp_tog = !m_q.rsp_tog;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            m_q <= '0;
        end else begin
            m_q <= m_d;
        end
    end

endmodule : tag_link_xfer

`default_nettype wire

//--- test/tag_core_props.sv
// assertions on the link ports of the tag command core
// assumes it is bound to tag_core; params header on the include path
`timescale 1ns/100ps
`default_nettype none
`include "tag_core_params.svh"
module tag_core_props #(
    parameter logic [63:0] UNIQUE_IDENTIFIER = 64'h0
)(
    // core clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // link side
    input wire logic LCLK,
    input wire logic REQ_VALID,
    input wire tag_core_pkg::req_t REQ,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire tag_core_pkg::rsp_t RSP
);
    tag_core_pkg::req_t last_q;
    logic dead_q;
    wire logic take = REQ_VALID && REQ_READY;
    wire logic [7:0] lc = last_q.cmd;
    // last request taken, and whether a kill was answered without error
    always_ff @(posedge LCLK) begin
        if (take) last_q <= REQ;
        dead_q <= RST_N && (dead_q || (RSP_VALID && lc == `CMD_KILL && !RSP.err));
    end
    default clocking cb @(posedge LCLK); endclocking
    default disable iff (!RST_N);
    property p_pulse; RSP_VALID |=> !RSP_VALID; endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
    property p_sol; RSP_VALID |-> REQ_READY && !$past(REQ_READY); endproperty
    a_sol: assert property (p_sol) else $error("answer without request");
    property p_busy; take |=> !REQ_READY; endproperty
    a_busy: assert property (p_busy) else $error("ready after take");
    property p_bound; take |-> ##[1:20] REQ_READY; endproperty
    a_bound: assert property (p_bound) else $error("request never done");
    property p_range;
        RSP_VALID && last_q.blk > 8'd63 && (lc == `CMD_READ_BLK || lc == `CMD_WRITE_BLK)
        |-> RSP.err && RSP.code == `ERR_RANGE;
    endproperty
    a_range: assert property (p_range) else $error("block range not refused");
    property p_quiet; RSP_VALID |-> lc != `CMD_STAY_QUIET; endproperty
    a_quiet: assert property (p_quiet) else $error("stay quiet answered");
    property p_uid; RSP_VALID && lc == `CMD_INVENTORY |-> !RSP.err && RSP.data == UNIQUE_IDENTIFIER; endproperty
    a_uid: assert property (p_uid) else $error("inventory identifier wrong");
    property p_dead; RSP_VALID |-> !dead_q; endproperty
    a_dead: assert property (p_dead) else $error("answer after kill");
endmodule : tag_core_props
bind tag_core tag_core_props #(.UNIQUE_IDENTIFIER(UNIQUE_IDENTIFIER)) props (.MCLK(MCLK), .RST_N(RST_N), .LCLK(LCLK),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP));
`default_nettype wire

//--- test/tag_reader_model.sv
// reader model: offers one request and collects the answer
// assumes the tag_core link handshake on lclk
`timescale 1ns/100ps
`default_nettype none
module tag_reader_model (
    // link clock
    input wire logic lclk,
    // request
    output logic req_valid,
    output tag_core_pkg::req_t req,
    input wire logic req_ready,
    // answer
    input wire logic rsp_valid,
    input wire tag_core_pkg::rsp_t rsp
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // reader speaks first, one request at a time
    task automatic xfer(input tag_core_pkg::req_t r, input int idle, output logic got,
            output tag_core_pkg::rsp_t a);
        int n;
        got = 1'b0;
        a = '0;
        n = 0;
        repeat (idle) @(posedge lclk);
        do begin
            @(posedge lclk);
            #1;
            n++;
        end while (!req_ready && n < 40);
        req = r;
        req_valid = 1'b1;
        @(posedge lclk);
        #1;
        req_valid = 1'b0;
        req = ~r;
        n = 0;
        do begin
            @(posedge lclk);
            #1;
            n++;
            if (rsp_valid) begin
                got = 1'b1;
                a = rsp;
            end
        end while (!req_ready && n < 40);
    endtask : xfer
endmodule : tag_reader_model
`default_nettype wire

//--- test/vicinity_tag_memory_command_core_bench.sv
// bench for the tag command core driven through the reader model
// assumes design/ on the include path; clocks of 40 ns and 48 ns
`timescale 1ns/100ps
`default_nettype none
`include "tag_core_params.svh"
module vicinity_tag_memory_command_core_bench;
    localparam logic [63:0] UID_V = 64'h5a5a_1234_8765_a5a5; // arbitrary value
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid, req_ready, rsp_valid, got;
    tag_core_pkg::req_t req;
    tag_core_pkg::rsp_t rsp, a;
    logic [63:0] uid_x = UID_V;
    int idle = 0;
    int err_total = 0;
    int n_compared = 0;
    always #20 mclk = ~mclk;
    always #24 lclk = ~lclk;
    tag_core #(.UNIQUE_IDENTIFIER(UID_V)) uut (.MCLK(mclk), .RST_N(rst_n), .LCLK(lclk), .REQ_VALID(req_valid),
        .REQ(req), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP(rsp));
    tag_reader_model rdr (.lclk(lclk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic do_reset;
        @(posedge mclk);
        #1 rst_n = 1'b0;
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge lclk);
    endtask : do_reset
    // one command; g answered, e error
    task automatic tx(input logic g, e, input logic [7:0] c, b, input logic [31:0] d,
            input logic [7:0] f = 8'h00, p = 8'h00);
        rdr.xfer('{f, c, b, p, uid_x, d}, idle, got, a);
        chk(64'({req_ready, got, a.err}), 64'({1'b1, g, e}));
    endtask : tx
    task automatic dat(input logic [31:0] d, input logic [7:0] s);
        chk(64'({a.stat, a.data[31:0]}), 64'({s, d}));
    endtask : dat
    task automatic t_memory;
        tx(1, 0, `CMD_WRITE_BLK, 8'd0, 32'hdead_beef);
        tx(1, 0, `CMD_WRITE_BLK, 8'd63, 32'h1234_5678);
        tx(1, 1, `CMD_WRITE_BLK, 8'd64, 32'h0);
        chk(64'(a.code), 64'(`ERR_RANGE));
        tx(1, 1, `CMD_READ_BLK, 8'd255, 32'h0);
        tx(1, 0, `CMD_READ_BLK, 8'd63, 32'h0);
        dat(32'h1234_5678, 8'h00);
        tx(1, 0, `CMD_READ_BLK, 8'd0, 32'h0);
        dat(32'hdead_beef, 8'h00);
    endtask : t_memory
    task automatic t_lock;
        tx(1, 0, `CMD_WRITE_BLK, 8'd5, 32'h0000_00a5);
        tx(1, 0, `CMD_LOCK_BLK, 8'd5, 32'h0);
        tx(1, 1, `CMD_WRITE_BLK, 8'd5, 32'hffff_ffff);
        chk(64'(a.code), 64'(`ERR_LOCKED));
        tx(1, 1, `CMD_LOCK_BLK, 8'd5, 32'h0);
        tx(1, 0, `CMD_READ_BLK, 8'd5, 32'h0);
        dat(32'h0000_00a5, 8'h01);
        tx(1, 0, `CMD_MULTI_SEC, 8'd4, 32'h0);
        chk(64'(a.data[31:0]), 64'h0000_0100);
    endtask : t_lock
    task automatic t_ids;
        tx(1, 0, `CMD_WRITE_AFI, 8'd0, 32'h5a);
        tx(1, 0, `CMD_LOCK_AFI, 8'd0, 32'h0);
        tx(1, 1, `CMD_WRITE_AFI, 8'd0, 32'h33);
        tx(1, 0, `CMD_WRITE_DSF, 8'd0, 32'hc3);
        tx(1, 0, `CMD_LOCK_DSF, 8'd0, 32'h0);
        tx(1, 1, `CMD_WRITE_DSF, 8'd0, 32'h3c);
        tx(1, 0, `CMD_SYS_INFO, 8'd0, 32'h0);
        chk(64'({a.b0, a.b1}), 64'hc35a);
        chk(a.data, UID_V);
        tx(1, 0, `CMD_INVENTORY, 8'd0, 32'h0, 8'h10, 8'h5a);
        tx(0, 0, `CMD_INVENTORY, 8'd0, 32'h0, 8'h10, 8'h33);
    endtask : t_ids
    task automatic t_pwd;
        idle = 3;
        tx(1, 0, `CMD_WRITE_BLK, 8'd10, 32'h0bad_cafe);
        tx(1, 0, `CMD_WRITE_PWD, 8'd0, 32'h1111_2222, 8'h00, 8'h01);
        tx(1, 0, `CMD_LOCK_PWD, 8'd0, 32'h0, 8'h80, 8'h01);
        tx(1, 0, `CMD_LOCK_PWD, 8'd10, 32'h0000_000c);
        tx(1, 1, `CMD_READ_BLK, 8'd10, 32'h0);
        chk(64'(a.code), 64'(`ERR_DENIED));
        tx(1, 1, `CMD_PRESENT_PWD, 8'd0, 32'h1111_2223, 8'h00, 8'h01);
        chk(64'(a.code), 64'(`ERR_PWD));
        tx(1, 0, `CMD_PRESENT_PWD, 8'd0, 32'h1111_2222, 8'h00, 8'h01);
        tx(1, 0, `CMD_WRITE_BLK, 8'd10, 32'h0000_0001);
        tx(1, 1, `CMD_LOCK_PWD, 8'd10, 32'h0000_0002);
        chk(64'(a.code), 64'(`ERR_LOCKED));
        tx(1, 0, `CMD_READ_BLK, 8'd10, 32'h0);
        dat(32'h0000_0001, 8'h0d);
        idle = 0;
    endtask : t_pwd
    task automatic t_states;
        tx(0, 0, `CMD_INV_INIT, 8'd0, 32'h0);
        tx(1, 0, `CMD_INIT, 8'd0, 32'h0);
        tx(1, 0, `CMD_INV_INIT, 8'd0, 32'h0);
        tx(1, 0, `CMD_FAST_INV_INIT, 8'd0, 32'h0);
        tx(0, 0, `CMD_STAY_QUIET, 8'd0, 32'h0, 8'h20);
        tx(0, 0, `CMD_INVENTORY, 8'd0, 32'h0);
        tx(1, 0, `CMD_RESET_RDY, 8'd0, 32'h0, 8'h20);
        tx(1, 0, `CMD_INVENTORY, 8'd0, 32'h0);
        tx(0, 0, `CMD_READ_BLK, 8'd0, 32'h0, 8'h10);
        tx(1, 0, `CMD_SELECT, 8'd0, 32'h0, 8'h20);
        tx(1, 0, `CMD_READ_BLK, 8'd0, 32'h0, 8'h10);
        dat(32'hdead_beef, 8'h00);
        uid_x = ~UID_V;
        tx(0, 0, `CMD_READ_BLK, 8'd0, 32'h0, 8'h20);
        uid_x = UID_V;
        tx(1, 0, `CMD_RESET_RDY, 8'd0, 32'h0, 8'h20);
        tx(1, 0, `CMD_FAST_READ, 8'd0, 32'h0);
        dat(32'hdead_beef, 8'h00);
        tx(1, 0, `CMD_FAST_INIT, 8'd0, 32'h0);
        chk(a.data, UID_V);
        tx(1, 1, 8'h55, 8'd0, 32'h0);
        chk(64'(a.code), 64'(`ERR_UNSUP));
    endtask : t_states
    task automatic t_kill;
        tx(1, 0, `CMD_WRITE_PWD, 8'd0, 32'h7777_0000);
        tx(1, 0, `CMD_LOCK_PWD, 8'd0, 32'h0, 8'h80);
        tx(1, 1, `CMD_KILL, 8'd0, 32'h7777_0001, 8'h20);
        chk(64'(a.code), 64'(`ERR_PWD));
        tx(1, 0, `CMD_KILL, 8'd0, 32'h7777_0000, 8'h20);
        tx(0, 0, `CMD_INVENTORY, 8'd0, 32'h0);
        tx(0, 0, `CMD_READ_BLK, 8'd0, 32'h0);
        do_reset();
        tx(1, 0, `CMD_READ_BLK, 8'd0, 32'h0);
        dat(32'h0, 8'h00);
    endtask : t_kill
    initial begin
        do_reset();
        t_memory();
        t_lock();
        t_ids();
        t_pwd();
        t_states();
        t_kill();
        complete_run();
    end
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
endmodule : vicinity_tag_memory_command_core_bench
`default_nettype wire
